/* common/pcrb_pkg.sv */
// Constants and types for the paged control register bank
package pcrb_pkg;

  // Register offsets
  localparam logic [7:0] OFF_PAGE        = 8'h00;
  localparam logic [7:0] OFF_SWRST       = 8'h01;
  localparam logic [7:0] OFF_SLEEP       = 8'h02;
  localparam logic [7:0] OFF_CH6_SETUP4  = 8'h59;
  localparam logic [7:0] OFF_CH7_SETUP2  = 8'h5c;
  localparam logic [7:0] OFF_CH7_SETUP3  = 8'h5d;
  localparam logic [7:0] OFF_CH7_SETUP4  = 8'h5e;
  localparam logic [7:0] OFF_CH8_SETUP2  = 8'h61;
  localparam logic [7:0] OFF_CH8_SETUP3  = 8'h62;
  localparam logic [7:0] OFF_CH8_SETUP4  = 8'h63;
  localparam logic [7:0] OFF_SIGP_SETUP0 = 8'h6b;
  localparam logic [7:0] OFF_SIGP_SETUP1 = 8'h6c;
  localparam logic [7:0] OFF_AGAIN_SETUP = 8'h70;
  localparam logic [7:0] OFF_INPUT_CHANNEL_ENABLES    = 8'h73;
  localparam logic [7:0] OFF_OUT_CH_EN   = 8'h74;
  localparam logic [7:0] OFF_PWR_UP_CFG  = 8'h75;
  localparam logic [7:0] OFF_DEV_STATE0  = 8'h76;
  localparam logic [7:0] OFF_DEV_STATE1  = 8'h77;
  localparam logic [7:0] OFF_BUS_CKSUM   = 8'h7e;

  // Page that holds the control registers
  localparam logic [7:0] PAGE_CTRL       = 8'h00;

  // Reset values
  localparam logic [7:0] PAGE_RST        = 8'h00;
  localparam logic       SWRST_RST       = 1'b0;
  localparam logic [7:0] SLEEP_RST       = 8'h00;

  // Field positions and masks
  localparam int         SWRST_BIT       = 0;
  localparam logic [7:0] SLEEP_WR_MASK   = 8'hfd;

  // Fixed broadcast target address
  localparam logic [6:0] BCAST_ADDR      = 7'h4c;

  // Quick-charge durations, nominal
  localparam int         CLK_HZ          = 50_000_000;
  localparam real        QCHG0_MS        = 3.5;
  localparam real        QCHG1_MS        = 10.0;
  localparam real        QCHG2_MS        = 50.0;
  localparam real        QCHG3_MS        = 100.0;
  localparam int         QCHG0_CYC       = int'(QCHG0_MS * CLK_HZ / 1000.0);
  localparam int         QCHG1_CYC       = int'(QCHG1_MS * CLK_HZ / 1000.0);
  localparam int         QCHG2_CYC       = int'(QCHG2_MS * CLK_HZ / 1000.0);
  localparam int         QCHG3_CYC       = int'(QCHG3_MS * CLK_HZ / 1000.0);
  localparam int         QCHG_CNT_W      = 23;

  // Sleep and supply configuration layout
  typedef struct packed {
    logic       analog_supply_source_sel;
    logic [1:0] rsv_rw;
    logic [1:0] reference_fast_charge_time;
    logic       broadcast_address_enable;
    logic       rsv_ro;
    logic       wake_enable_n;
  } pcrb_sleep_cfg_t;

  // Control bus pins after synchronisation
  typedef struct packed {
    logic scl;
    logic sda;
  } pcrb_bus_t;

  // Control bus target states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ADDR  = 7'b0000010,
    ST_ACK   = 7'b0000100,
    ST_REG   = 7'b0001000,
    ST_WDATA = 7'b0010000,
    ST_RDATA = 7'b0100000,
    ST_RACK  = 7'b1000000
  } pcrb_state_t;

endpackage : pcrb_pkg

/* design/pcrb_bank.sv */
// Paged control register bank with serial control bus target
`timescale 1ns/1ns
module pcrb_bank #(
  parameter int          STRAP_W    = 2,
  parameter logic [6:0]  STRAP_BASE = 7'h48,
  parameter int unsigned QCHG_CYC0  = pcrb_pkg::QCHG0_CYC,
  parameter int unsigned QCHG_CYC1  = pcrb_pkg::QCHG1_CYC,
  parameter int unsigned QCHG_CYC2  = pcrb_pkg::QCHG2_CYC,
  parameter int unsigned QCHG_CYC3  = pcrb_pkg::QCHG3_CYC
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // Serial control bus, open drain data
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe,
  // Address strap pins
  input  wire logic [STRAP_W-1:0] addr_strap,
  // Configuration outputs
  output logic [7:0]              page_sel,
  output logic                    soft_reset_pulse,
  output logic                    analog_supply_source_sel,
  output logic [1:0]              reference_fast_charge_time,
  output logic                    broadcast_address_enable,
  output logic                    sleep_mode,
  output logic                    ref_fast_charge_active
);

  localparam int CW = pcrb_pkg::QCHG_CNT_W;

  if (STRAP_W < 1 || STRAP_W > 6) begin : g_chk_strap
    $error("STRAP_W must lie between 1 and 6");
  end
  if (QCHG_CYC0 < 1 || QCHG_CYC1 < 1 || QCHG_CYC2 < 1 || QCHG_CYC3 < 1) begin : g_chk_min
    $error("Quick-charge counts must be at least one");
  end
  if (QCHG_CYC0 >= 2**CW || QCHG_CYC1 >= 2**CW || QCHG_CYC2 >= 2**CW ||
      QCHG_CYC3 >= 2**CW) begin : g_chk_max
    $error("Quick-charge counts exceed the counter");
  end

  // Reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Input synchronisation
  pcrb_pkg::pcrb_bus_t  bus_s;
  pcrb_pkg::pcrb_bus_t  bus_p_q;
  logic [STRAP_W-1:0]   strap_s;

  pcrb_sync #(
    .W    (2),
    .INIT (2'h3)
  ) u_bus_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_q),
    .d       ({scl_i, sda_i}),
    .q       (bus_s)
  );

  pcrb_sync #(
    .W    (STRAP_W),
    .INIT ('0)
  ) u_strap_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_q),
    .d       (addr_strap),
    .q       (strap_s)
  );

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_p_q <= 2'h3;
    end else begin
      bus_p_q <= bus_s;
    end
  end

  // Bus condition detection
  wire scl_rise  = bus_s.scl & ~bus_p_q.scl;
  wire scl_fall  = ~bus_s.scl & bus_p_q.scl;
  wire start_det = bus_s.scl & bus_p_q.scl & bus_p_q.sda & ~bus_s.sda;
  wire stop_det  = bus_s.scl & bus_p_q.scl & ~bus_p_q.sda & bus_s.sda;

  // Register state
  logic [7:0]                page_q;
  logic                      swrst_q;
  pcrb_pkg::pcrb_sleep_cfg_t sleep_q;
  logic                      sleep_mode_q;
  logic                      qchg_active_q;
  logic [CW-1:0]             qchg_cnt_q;

  // Target address selection
  wire [6:0] strap_addr = {STRAP_BASE[6:STRAP_W], strap_s};
  wire [6:0] my_addr    = sleep_q.broadcast_address_enable ? pcrb_pkg::BCAST_ADDR
                                                           : strap_addr;

  // Bus target state
  pcrb_pkg::pcrb_state_t st_q;
  pcrb_pkg::pcrb_state_t st_d;
  pcrb_pkg::pcrb_state_t nxt_q;
  pcrb_pkg::pcrb_state_t nxt_d;
  logic [3:0]            bit_q;
  logic [3:0]            bit_d;
  logic [7:0]            shift_q;
  logic [7:0]            shift_d;
  logic [7:0]            tx_q;
  logic [7:0]            tx_d;
  logic [7:0]            ptr_q;
  logic [7:0]            ptr_d;
  logic                  oe_q;
  logic                  oe_d;
  logic                  nack_q;
  logic                  nack_d;
  logic                  wr_en;

  // Read data selection
  wire       on_ctrl_page = (page_q == pcrb_pkg::PAGE_CTRL);
  wire [7:0] sleep_rd     = sleep_q & pcrb_pkg::SLEEP_WR_MASK;
  wire [7:0] rd_byte      =
    (ptr_q == pcrb_pkg::OFF_PAGE)                  ? page_q :
    (on_ctrl_page && ptr_q == pcrb_pkg::OFF_SWRST) ? {7'h00, swrst_q} :
    (on_ctrl_page && ptr_q == pcrb_pkg::OFF_SLEEP) ? sleep_rd :
                                                     8'h00;
  wire       addr_match   = (shift_q[7:1] == my_addr);
  wire       byte_done    = scl_fall && (bit_q == 4'h8);

  // Write decode
  wire wr_page  = wr_en && (ptr_q == pcrb_pkg::OFF_PAGE);
  wire wr_swrst = wr_en && on_ctrl_page && (ptr_q == pcrb_pkg::OFF_SWRST);
  wire wr_sleep = wr_en && on_ctrl_page && (ptr_q == pcrb_pkg::OFF_SLEEP);

  always_comb begin
    st_d    = st_q;
    nxt_d   = nxt_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    tx_d    = tx_q;
    ptr_d   = ptr_q;
    oe_d    = oe_q;
    nack_d  = nack_q;
    wr_en   = 1'b0;
    if (stop_det) begin
      st_d = pcrb_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else if (start_det) begin
      st_d  = pcrb_pkg::ST_ADDR;
      bit_d = 4'h0;
      oe_d  = 1'b0;
    end else begin
      case (st_q)
        pcrb_pkg::ST_ADDR, pcrb_pkg::ST_REG, pcrb_pkg::ST_WDATA: begin
          if (scl_rise && bit_q != 4'h8) begin
            shift_d = {shift_q[6:0], bus_s.sda};
            bit_d   = bit_q + 4'h1;
          end else if (byte_done) begin
            bit_d = 4'h0;
            st_d  = pcrb_pkg::ST_ACK;
            oe_d  = 1'b1;
            if (st_q == pcrb_pkg::ST_ADDR) begin
              nxt_d = shift_q[0] ? pcrb_pkg::ST_RDATA : pcrb_pkg::ST_REG;
              if (!addr_match) begin
                st_d = pcrb_pkg::ST_IDLE;
                oe_d = 1'b0;
              end
            end else if (st_q == pcrb_pkg::ST_REG) begin
              ptr_d = shift_q;
              nxt_d = pcrb_pkg::ST_WDATA;
            end else begin
              wr_en = 1'b1;
              ptr_d = ptr_q + 8'h01;
              nxt_d = pcrb_pkg::ST_WDATA;
            end
          end
        end
        pcrb_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (nxt_q == pcrb_pkg::ST_RDATA) begin
              tx_d  = rd_byte;
              ptr_d = ptr_q + 8'h01;
              oe_d  = ~rd_byte[7];
              bit_d = 4'h0;
            end else begin
              oe_d = 1'b0;
            end
            st_d = nxt_q;
          end
        end
        pcrb_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bit_q == 4'h7) begin
              oe_d = 1'b0;
              st_d = pcrb_pkg::ST_RACK;
            end else begin
              bit_d = bit_q + 4'h1;
              tx_d  = {tx_q[6:0], 1'b0};
              oe_d  = ~tx_q[6];
            end
          end
        end
        pcrb_pkg::ST_RACK: begin
          if (scl_rise) begin
            nack_d = bus_s.sda;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_d = pcrb_pkg::ST_IDLE;
            end else begin
              tx_d  = rd_byte;
              ptr_d = ptr_q + 8'h01;
              oe_d  = ~rd_byte[7];
              bit_d = 4'h0;
              st_d  = pcrb_pkg::ST_RDATA;
            end
          end
        end
        pcrb_pkg::ST_IDLE: begin
          oe_d = 1'b0;
        end
        default: begin
          st_d = pcrb_pkg::ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q    <= pcrb_pkg::ST_IDLE;
      nxt_q   <= pcrb_pkg::ST_IDLE;
      bit_q   <= 4'h0;
      shift_q <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 8'h00;
      oe_q    <= 1'b0;
      nack_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      nxt_q   <= nxt_d;
      bit_q   <= bit_d;
      shift_q <= shift_d;
      tx_q    <= tx_d;
      ptr_q   <= ptr_d;
      oe_q    <= oe_d;
      nack_q  <= nack_d;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      page_q  <= pcrb_pkg::PAGE_RST;
      swrst_q <= pcrb_pkg::SWRST_RST;
      sleep_q <= pcrb_pkg::SLEEP_RST;
    end else if (swrst_q) begin
      page_q  <= pcrb_pkg::PAGE_RST;
      sleep_q <= pcrb_pkg::SLEEP_RST;
      swrst_q <= 1'b0;
    end else begin
      if (wr_page) begin
        page_q <= shift_q;
      end
      if (wr_swrst) begin
        swrst_q <= shift_q[pcrb_pkg::SWRST_BIT];
      end
      if (wr_sleep) begin
        sleep_q <= shift_q & pcrb_pkg::SLEEP_WR_MASK;
      end
    end
  end

  // Sleep state and reference quick charge on wake
  wire           qchg_start = sleep_mode_q && sleep_q.wake_enable_n;
  wire [CW-1:0]  qchg_dur   =
    (sleep_q.reference_fast_charge_time == 2'h0) ? CW'(QCHG_CYC0) :
    (sleep_q.reference_fast_charge_time == 2'h1) ? CW'(QCHG_CYC1) :
    (sleep_q.reference_fast_charge_time == 2'h2) ? CW'(QCHG_CYC2) :
                                                   CW'(QCHG_CYC3);

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sleep_mode_q  <= 1'b1;
      qchg_active_q <= 1'b0;
      qchg_cnt_q    <= '0;
    end else begin
      sleep_mode_q <= ~sleep_q.wake_enable_n;
      if (qchg_start) begin
        qchg_active_q <= 1'b1;
        qchg_cnt_q    <= qchg_dur - CW'(1);
      end else if (sleep_mode_q || qchg_cnt_q == '0) begin
        qchg_active_q <= 1'b0;
      end else begin
        qchg_cnt_q <= qchg_cnt_q - CW'(1);
      end
    end
  end

  // Outputs
  assign sda_o                      = 1'b0;
  assign sda_oe                     = oe_q;
  assign page_sel                   = page_q;
  assign soft_reset_pulse           = swrst_q;
  assign analog_supply_source_sel   = sleep_q.analog_supply_source_sel;
  assign reference_fast_charge_time = sleep_q.reference_fast_charge_time;
  assign broadcast_address_enable   = sleep_q.broadcast_address_enable;
  assign sleep_mode                 = sleep_mode_q;
  assign ref_fast_charge_active     = qchg_active_q;

  // Checks
  page_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    wr_page && !swrst_q |=> page_sel == $past(shift_q))
    else $error("Page select did not take the written value");

  swrst_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    wr_swrst && shift_q[0] && !swrst_q |=> soft_reset_pulse)
    else $error("Soft reset not triggered by a one");

  swrst_dflt_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    soft_reset_pulse |=> page_sel == pcrb_pkg::PAGE_RST && sleep_q == pcrb_pkg::SLEEP_RST
    ##1 sleep_mode)
    else $error("Soft reset left a register off its default");

  swrst_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    wr_swrst && !shift_q[0] && !swrst_q |=> !soft_reset_pulse)
    else $error("Writing zero triggered a soft reset");

  swrst_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    soft_reset_pulse |=> !soft_reset_pulse)
    else $error("Soft reset bit did not clear itself");

  supply_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    wr_sleep && !swrst_q |=> analog_supply_source_sel == $past(shift_q[7]))
    else $error("Supply source select not updated");

  qchg_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    qchg_start |=> ref_fast_charge_active && qchg_cnt_q == $past(qchg_dur) - CW'(1))
    else $error("Quick-charge counter loaded with wrong duration");

  bcast_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    broadcast_address_enable && byte_done && st_q == pcrb_pkg::ST_ADDR
    |=> (st_q == pcrb_pkg::ST_ACK) == ($past(shift_q[7:1]) == 7'h4c))
    else $error("Broadcast address not answered");

  strap_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    !broadcast_address_enable && byte_done && st_q == pcrb_pkg::ST_ADDR
    |=> (st_q == pcrb_pkg::ST_ACK) ==
        ($past(shift_q[7:1]) == {STRAP_BASE[6:STRAP_W], $past(strap_s)}))
    else $error("Target address does not follow straps");

  sleep_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    ##1 sleep_mode == !$past(sleep_q.wake_enable_n))
    else $error("Sleep mode does not follow wake bit");

  rsv_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    sleep_rd[1] == 1'b0 && (ptr_q != 8'h01 || rd_byte[7:1] == 7'h00))
    else $error("Reserved read-only bit reads non-zero");

endmodule : pcrb_bank

/* design/pcrb_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pcrb_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Asynchronous input and filtered output
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;

  if (W < 1) begin : g_chk
    $error("pcrb_sync width must be at least one");
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q_q  <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Only a level seen on two stages counts
      if (s2_q == s3_q) begin
        q_q <= s3_q;
      end
    end
  end

  assign q = q_q;

endmodule : pcrb_sync

/* testbench/pcrb_host_model.sv */
// Behavioural host controller driving the serial control bus
`timescale 1ns/1ns
module pcrb_host_model #(
  parameter int HALF = 10
) (
  // Clock
  input  wire logic clk_sys,
  // Bus lines, data line is open drain with pull-up
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  logic [6:0] tgt_addr;

  initial begin
    scl      = 1'b1;
    sda_low  = 1'b0;
    tgt_addr = 7'h00;
  end

  // Set both lines just after an edge, then hold for HALF clock cycles, a third of a bit
  task automatic put(input logic s, input logic l);
    @(posedge clk_sys);
    scl     <= s;
    sda_low <= l;
    repeat (HALF - 1) @(posedge clk_sys);
  endtask : put

  // Data changes only while the bus clock is low
  task automatic bitx(input logic l, output logic v);
    put(1'b0, l);
    put(1'b1, l);
    @(negedge clk_sys);
    v = sda_line;
    put(1'b0, l);
  endtask : bitx

  // Also serves as repeated start
  task automatic start();
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
    put(1'b0, 1'b1);
  endtask : start

  task automatic stop();
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
  endtask : stop

  // One byte out, MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic host_ack,
                      output logic [7:0] rx, output logic acked);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bitx(~tx[i], v);
      rx[i] = v;
    end
    bitx(host_ack, v);
    acked = ~v;
  endtask : xfer

  task automatic wr(input logic [7:0] ptr, input logic [7:0] dat, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer({tgt_addr, 1'b0}, 1'b0, rx, a0);
    xfer(ptr, 1'b0, rx, a1);
    xfer(dat, 1'b0, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr

  // Pointer write, repeated start, one byte read and refused
  task automatic rd(input logic [7:0] ptr, output logic [7:0] dat, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start();
    xfer({tgt_addr, 1'b0}, 1'b0, rx, a0);
    xfer(ptr, 1'b0, rx, a1);
    start();
    xfer({tgt_addr, 1'b1}, 1'b0, rx, a2);
    xfer(8'hff, 1'b0, dat, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask : rd
endmodule : pcrb_host_model

/* testbench/tb_paged_control_register_bank.sv */
// Self-checking bench for the paged control register bank
`timescale 1ns/1ns
module tb_paged_control_register_bank;
  localparam int unsigned QC [4] = '{40, 80, 120, 160};
  localparam logic [4:0]  BASE_HI = 5'b10010;

  logic       clk_sys;
  logic       rstn;
  logic       scl;
  logic       sda_low;
  wire        sda_line;
  logic [1:0] addr_strap;
  logic       sda_o;
  logic       sda_oe;
  logic [7:0] page_sel;
  logic       soft_reset_pulse;
  logic       analog_supply_source_sel;
  logic [1:0] reference_fast_charge_time;
  logic       broadcast_address_enable;
  logic       sleep_mode;
  logic       ref_fast_charge_active;
  int         error_cnt = 0;
  int         checks_done = 0;
  int         pulse_cyc = 0;
  int         chg_cnt = 0;
  int         chg_len = 0;

  assign sda_line = ~((sda_oe & ~sda_o) | sda_low);

  pcrb_bank #(
    .QCHG_CYC0 (QC[0]),
    .QCHG_CYC1 (QC[1]),
    .QCHG_CYC2 (QC[2]),
    .QCHG_CYC3 (QC[3])
  ) DUT (
    .clk_sys                    (clk_sys),
    .rstn                       (rstn),
    .scl_i                      (scl),
    .sda_i                      (sda_line),
    .sda_o                      (sda_o),
    .sda_oe                     (sda_oe),
    .addr_strap                 (addr_strap),
    .page_sel                   (page_sel),
    .soft_reset_pulse           (soft_reset_pulse),
    .analog_supply_source_sel   (analog_supply_source_sel),
    .reference_fast_charge_time (reference_fast_charge_time),
    .broadcast_address_enable   (broadcast_address_enable),
    .sleep_mode                 (sleep_mode),
    .ref_fast_charge_active     (ref_fast_charge_active)
  );

  pcrb_host_model host (
    .clk_sys  (clk_sys),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_low  (sda_low)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Length of reset pulses and of each quick-charge run
  always @(posedge clk_sys) begin
    if (soft_reset_pulse === 1'b1) begin
      pulse_cyc <= pulse_cyc + 1;
    end
    if (ref_fast_charge_active === 1'b1) begin
      chg_cnt <= chg_cnt + 1;
    end else if (chg_cnt != 0) begin
      chg_len <= chg_cnt;
      chg_cnt <= 0;
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic wrc(input logic [7:0] ptr, input logic [7:0] dat);
    logic ok;
    host.wr(ptr, dat, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask : wrc

  task automatic rdc(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.rd(ptr, d, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk("read data", exp, d);
  endtask : rdc

  // A target that does not answer at this address
  task automatic nak(input logic [6:0] a);
    logic [7:0] d;
    logic       ok;
    logic [6:0] keep;
    keep = host.tgt_addr;
    host.tgt_addr = a;
    host.rd(pcrb_pkg::OFF_PAGE, d, ok);
    host.tgt_addr = keep;
    chk("address ack", 8'h00, {7'h00, ok});
  endtask : nak

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (95000) @(posedge clk_sys);
    error_cnt++;
    finish_test();
  end

  initial begin
    rstn       = 1'b0;
    addr_strap = 2'b01;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    host.tgt_addr = {BASE_HI, 2'b01};
    repeat (10) @(posedge clk_sys);
    chk("sleep_mode", 8'h01, {7'h00, sleep_mode});
    chk("page_sel", 8'h00, page_sel);
    rdc(pcrb_pkg::OFF_PAGE, 8'h00);
    rdc(pcrb_pkg::OFF_SWRST, 8'h00);
    rdc(pcrb_pkg::OFF_SLEEP, 8'h00);
    // Top page, control registers hidden there
    wrc(pcrb_pkg::OFF_PAGE, 8'hff);
    chk("page_sel", 8'hff, page_sel);
    wrc(pcrb_pkg::OFF_SLEEP, 8'h81);
    rdc(pcrb_pkg::OFF_SLEEP, 8'h00);
    rdc(pcrb_pkg::OFF_PAGE, 8'hff);
    wrc(pcrb_pkg::OFF_PAGE, 8'h00);
    chk("sleep_mode", 8'h01, {7'h00, sleep_mode});
    // Every quick-charge code, started by waking
    for (int c = 0; c < 4; c++) begin
      wrc(pcrb_pkg::OFF_SLEEP, 8'h00);
      chk("sleep_mode", 8'h01, {7'h00, sleep_mode});
      wrc(pcrb_pkg::OFF_SLEEP, {3'b000, c[1:0], 3'b001});
      chk("code", {6'h00, c[1:0]}, {6'h00, reference_fast_charge_time});
      repeat (200) @(posedge clk_sys);
      chk("charge cycles", QC[c][7:0], chg_len[7:0]);
    end
    chk("sleep_mode", 8'h00, {7'h00, sleep_mode});
    wrc(pcrb_pkg::OFF_SLEEP, 8'hfb);
    rdc(pcrb_pkg::OFF_SLEEP, 8'hf9);
    chk("supply", 8'h01, {7'h00, analog_supply_source_sel});
    wrc(pcrb_pkg::OFF_SLEEP, 8'h79);
    chk("supply", 8'h00, {7'h00, analog_supply_source_sel});
    // Broadcast address overrides the straps
    wrc(pcrb_pkg::OFF_SLEEP, 8'h05);
    chk("broadcast", 8'h01, {7'h00, broadcast_address_enable});
    nak({BASE_HI, 2'b01});
    host.tgt_addr = pcrb_pkg::BCAST_ADDR;
    rdc(pcrb_pkg::OFF_SLEEP, 8'h05);
    @(posedge clk_sys);
    addr_strap <= 2'b10;
    rdc(pcrb_pkg::OFF_SLEEP, 8'h05);
    wrc(pcrb_pkg::OFF_SLEEP, 8'h01);
    nak(pcrb_pkg::BCAST_ADDR);
    nak({BASE_HI, 2'b01});
    host.tgt_addr = {BASE_HI, 2'b10};
    rdc(pcrb_pkg::OFF_SLEEP, 8'h01);
    // Software reset
    wrc(pcrb_pkg::OFF_SLEEP, 8'h81);
    wrc(pcrb_pkg::OFF_SWRST, 8'h00);
    wrc(pcrb_pkg::OFF_SWRST, 8'hfe);
    rdc(pcrb_pkg::OFF_SWRST, 8'h00);
    rdc(pcrb_pkg::OFF_SLEEP, 8'h81);
    chk("reset pulses", 8'h00, pulse_cyc[7:0]);
    wrc(pcrb_pkg::OFF_SWRST, 8'h01);
    chk("reset pulses", 8'h01, pulse_cyc[7:0]);
    rdc(pcrb_pkg::OFF_SWRST, 8'h00);
    rdc(pcrb_pkg::OFF_SLEEP, 8'h00);
    chk("sleep_mode", 8'h01, {7'h00, sleep_mode});
    chk("supply", 8'h00, {7'h00, analog_supply_source_sel});
    finish_test();
  end
endmodule : tb_paged_control_register_bank
